// file: ccpd_pkg.sv
// Constants shared by the crank and cam pattern decoder.
// Assumes one system clock at 40 MHz and a word-indexed register port.
package ccpd_pkg;

    // Register indices on the plain register port
    localparam logic [5:0] CCPD_REG_CTRL     = 6'h00;
    localparam logic [5:0] CCPD_REG_TEETH    = 6'h01;
    localparam logic [5:0] CCPD_REG_DRV_MODE = 6'h02;
    localparam logic [5:0] CCPD_REG_CAM_COND = 6'h03;
    localparam logic [5:0] CCPD_REG_ONESHOT  = 6'h04;
    localparam logic [5:0] CCPD_REG_STATUS   = 6'h05;
    localparam logic [5:0] CCPD_REG_ANGLE    = 6'h06;
    localparam logic [5:0] CCPD_REG_DEGREES  = 6'h07;
    localparam logic [5:0] CCPD_REG_CAM1_CAP = 6'h08;
    localparam logic [5:0] CCPD_REG_CAM2_CAP = 6'h09;
    localparam logic [5:0] CCPD_REG_TDC_BASE = 6'h10;

    // Control register fields and the cam conditioning extension field
    localparam int CCPD_CTRL_PAT_LSB  = 0;
    localparam int CCPD_CTRL_C720     = 2;
    localparam int CCPD_CTRL_GAP_LSB  = 3;
    localparam int CCPD_CTRL_RETARD   = 5;
    localparam int CCPD_CTRL_REF_CAM  = 6;
    localparam int CCPD_CTRL_SYNC_EN  = 7;
    localparam int CCPD_CAM_EXT_LSB   = 8;

    // Values after reset
    localparam logic [7:0]  CCPD_CTRL_RST  = 8'h88;
    localparam logic [7:0]  CCPD_TEETH_RST = 8'h3c;
    localparam logic [15:0] CCPD_TDC_RST   = 16'h0000;

    // Wheel pattern families
    localparam logic [1:0] CCPD_PAT_ENCODER = 2'h0;
    localparam logic [1:0] CCPD_PAT_MISSING = 2'h1;
    localparam logic [1:0] CCPD_PAT_EXTRA   = 2'h2;

    // Fixed extrapolation level of each pattern family
    localparam logic [3:0] CCPD_LVL_ENCODER = 4'h7;
    localparam logic [3:0] CCPD_LVL_MISSING = 4'h7;
    localparam logic [3:0] CCPD_LVL_EXTRA   = 4'h9;

    // Degrees per crank revolution
    localparam logic [8:0] CCPD_DEG_PER_REV = 9'h168;

    // Degree divider iterations
    localparam logic [4:0] CCPD_DIV_STEPS = 5'h12;

    typedef enum logic [1:0] {CCPD_CAM_IDLE, CCPD_CAM_OFFS, CCPD_CAM_EXT} ccpd_cam_st_t;

endpackage

// file: ccpd_cam_cond.sv
// Cam conditioner: delays a cam rise by some crank teeth, then holds it high for some more teeth.
// Assumes tooth_pulse is a one-cycle pulse per crank tooth.
`timescale 1ns/100ps
module ccpd_cam_cond
    import ccpd_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Inputs
    input  wire logic       tooth_pulse,
    input  wire logic       cam_in,
    input  wire logic [7:0] offset_teeth,
    input  wire logic [7:0] extend_teeth,
    // Conditioned cam
    output logic            cam_out
);
    typedef struct packed {
        logic         cam_d;
        ccpd_cam_st_t st;
        logic [7:0]   cnt;
        logic         out;
    } ccpd_cc_state_t;

    ccpd_cc_state_t s_q;
    ccpd_cc_state_t s_d;

    always_comb begin
        s_d       = s_q;
        s_d.cam_d = cam_in;
        if ((offset_teeth == 8'h00) && (extend_teeth == 8'h00)) begin
            // Both zero leaves the cam unchanged
            s_d.st  = CCPD_CAM_IDLE;
            s_d.out = cam_in;
        end else begin
            case (s_q.st)
                CCPD_CAM_IDLE: begin
                    s_d.out = 1'b0;
                    if (cam_in && !s_q.cam_d) begin
                        if (offset_teeth == 8'h00) begin
                            s_d.st  = CCPD_CAM_EXT;
                            s_d.cnt = extend_teeth;
                            s_d.out = 1'b1;
                        end else begin
                            s_d.st  = CCPD_CAM_OFFS;
                            s_d.cnt = offset_teeth;
                        end
                    end
                end
                CCPD_CAM_OFFS: begin
                    if (tooth_pulse) begin
                        s_d.cnt = s_q.cnt - 8'h01;
                        if (s_q.cnt == 8'h01) begin
                            s_d.st  = CCPD_CAM_EXT;
                            s_d.cnt = extend_teeth;
                            s_d.out = 1'b1;
                        end
                    end
                end
                CCPD_CAM_EXT: begin
                    // An extension of zero still lasts until the next tooth
                    if (tooth_pulse) begin
                        if (s_q.cnt <= 8'h01) begin
                            s_d.st  = CCPD_CAM_IDLE;
                            s_d.out = 1'b0;
                        end else begin
                            s_d.cnt = s_q.cnt - 8'h01;
                        end
                    end
                end
                default: begin
                    s_d.st  = CCPD_CAM_IDLE;
                    s_d.out = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{cam_d: 1'b0, st: CCPD_CAM_IDLE, cnt: 8'h00, out: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign cam_out = s_q.out;

endmodule // ccpd_cam_cond

// file: ccpd_decoder.sv
// Crank and cam pattern decoder with angle tracker, per-channel top-dead-centre
// table, cam edge angle capture and manual one-shot triggers.
// Assumes all pin inputs are synchronous to clk; registers on a plain port.
`timescale 1ns/100ps
module ccpd_decoder
    import ccpd_pkg::*;
#(
    parameter int NUM_DI_CH  = 4,
    parameter int NUM_PFI_CH = 4,
    parameter int NUM_DRV    = 4
) (
    // Clock and reset
    input  wire logic                                  clk,
    input  wire logic                                  rstn,
    // Register port
    input  wire logic [5:0]                            reg_addr,
    input  wire logic [31:0]                           reg_wdata,
    input  wire logic                                  reg_wr,
    input  wire logic                                  reg_rd,
    output logic [31:0]                                reg_rdata,
    // Position sensor inputs
    input  wire logic                                  crank_in,
    input  wire logic                                  cam1_in,
    input  wire logic                                  cam2_in,
    input  wire logic                                  ref_in,
    // Results
    output logic                                       in_sync,
    output logic [18:0]                                angle_ticks,
    output logic [9:0]                                 angle_deg,
    output logic [NUM_PFI_CH-1:0]                      manual_oneshot_fire,
    output logic [(NUM_DI_CH+NUM_PFI_CH)*16-1:0]       tdc_values
);
    localparam int NCH = NUM_DI_CH + NUM_PFI_CH;

    typedef struct packed {
        logic [7:0]            ctrl;
        logic [7:0]            teeth;
        logic [NUM_DRV-1:0]    drv_mode;
        logic [15:0]           cam_cond;
        logic [7:0]            act_ctrl;
        logic [7:0]            act_teeth;
        logic [NUM_PFI_CH-1:0] oneshot;
        logic [NCH-1:0][15:0]  tdc;
        logic                  crank_d;
        logic                  ref_d;
        logic                  cam1_d;
        logic                  cam2_d;
        logic                  ref_seen;
        logic [19:0]           tcnt;
        logic [19:0]           tick_cnt;
        logic [19:0]           prev;
        logic [9:0]            idx;
        logic [8:0]            sub;
        logic                  sync;
        logic [18:0]           angle;
        logic [18:0]           cap1;
        logic [18:0]           cap2;
        logic                  div_busy;
        logic [4:0]            div_cnt;
        logic [17:0]           div_num;
        logic [8:0]            div_rem;
        logic [17:0]           div_q;
        logic [18:0]           div_src;
        logic [9:0]            deg;
        logic [31:0]           rdata;
    } ccpd_state_t;

    ccpd_state_t s_q;
    ccpd_state_t s_d;
    logic        cam_cond;
    logic        crank_rise;

    assign crank_rise = crank_in & ~s_q.crank_d;

    ccpd_cam_cond u_cam_cond (
        .clk          (clk),
        .rstn         (rstn),
        .tooth_pulse  (crank_rise),
        .cam_in       (cam1_in),
        .offset_teeth (s_q.cam_cond[7:0]),
        .extend_teeth (s_q.cam_cond[15:8]),
        .cam_out      (cam_cond)
    );

    always_comb begin
        logic [1:0]  pat;
        logic        c720;
        logic [1:0]  gap;
        logic        active;
        logic        cfg_err;
        logic        cam_eff;
        logic        phase_ref;
        logic [3:0]  lvl;
        logic [9:0]  positions;
        logic [9:0]  ref_pos;
        logic [9:0]  idx_inc;
        logic [8:0]  max_sub;
        logic [19:0] step;
        logic [19:0] period;
        logic        is_gap;
        logic        is_short;
        logic [27:0] prod;
        logic [8:0]  rem_sh;
        logic [5:0]  toff;
        s_d         = s_q;
        s_d.oneshot = '0;
        s_d.rdata   = 32'h0000_0000;
        s_d.crank_d = crank_in;
        s_d.cam1_d  = cam1_in;
        s_d.cam2_d  = cam2_in;

        // Register writes
        toff = reg_addr - CCPD_REG_TDC_BASE;
        if (reg_wr) begin
            case (reg_addr)
                CCPD_REG_CTRL:     s_d.ctrl     = reg_wdata[7:0];
                CCPD_REG_TEETH:    s_d.teeth    = reg_wdata[7:0];
                CCPD_REG_DRV_MODE: s_d.drv_mode = reg_wdata[NUM_DRV-1:0];
                CCPD_REG_CAM_COND: s_d.cam_cond = reg_wdata[15:0];
                CCPD_REG_ONESHOT:  s_d.oneshot  = reg_wdata[NUM_PFI_CH-1:0];
                default: begin
                    if ((reg_addr >= CCPD_REG_TDC_BASE) && (int'(toff) < NCH)) begin
                        s_d.tdc[toff] = reg_wdata[15:0];
                    end
                end
            endcase
        end

        // Working copy follows only in angle mode
        active = |s_q.drv_mode;
        if (active) begin
            s_d.act_ctrl  = s_q.ctrl;
            s_d.act_teeth = s_q.teeth;
        end
        pat     = s_q.act_ctrl[CCPD_CTRL_PAT_LSB+:2];
        c720    = s_q.act_ctrl[CCPD_CTRL_C720];
        gap     = s_q.act_ctrl[CCPD_CTRL_GAP_LSB+:2];
        cfg_err = (pat == 2'h3) || ((pat == CCPD_PAT_MISSING) && (gap != 2'h1) && (gap != 2'h2));
        cam_eff = c720 & cam_cond;

        // Phase reference input selection and masking
        if (c720 && s_q.act_ctrl[CCPD_CTRL_REF_CAM]) begin
            phase_ref = cam1_in;
        end else if (c720) begin
            phase_ref = ref_in & cam_cond;
        end else begin
            phase_ref = ref_in;
        end
        s_d.ref_d = phase_ref;

        case (pat)
            CCPD_PAT_MISSING: lvl = CCPD_LVL_MISSING;
            CCPD_PAT_EXTRA:   lvl = CCPD_LVL_EXTRA;
            default:          lvl = CCPD_LVL_ENCODER;
        endcase
        max_sub   = 9'((10'h001 << lvl) - 10'h001);
        positions = c720 ? {1'b0, s_q.act_teeth, 1'b0} : {2'b00, s_q.act_teeth};
        ref_pos   = (c720 && !cam_eff) ? {2'b00, s_q.act_teeth} : 10'h000;
        idx_inc   = ((s_q.idx + 10'h001) >= positions) ? 10'h000 : s_q.idx + 10'h001;
        step      = ((s_q.prev >> lvl) == 20'h00000) ? 20'h00001 : (s_q.prev >> lvl);
        period    = s_q.tcnt;
        is_gap    = (s_q.prev != 20'h00000) && (period > (s_q.prev + (s_q.prev >> 1)));
        is_short  = period < (s_q.prev >> 1);

        if (!active || cfg_err) begin
            s_d.sync     = 1'b0;
            s_d.idx      = 10'h000;
            s_d.sub      = 9'h000;
            s_d.tcnt     = 20'h00000;
            s_d.prev     = 20'h00000;
            s_d.ref_seen = 1'b0;
        end else begin
            if (s_q.tcnt != 20'hfffff) begin
                s_d.tcnt = s_q.tcnt + 20'h00001;
            end
            // Ticks between teeth hold at the last one until the tooth arrives
            if (s_q.tick_cnt + 20'h00001 >= step) begin
                s_d.tick_cnt = 20'h00000;
                if (s_q.sub < max_sub) begin
                    s_d.sub = s_q.sub + 9'h001;
                end
            end else begin
                s_d.tick_cnt = s_q.tick_cnt + 20'h00001;
            end
            if (phase_ref && !s_q.ref_d) begin
                s_d.ref_seen = 1'b1;
            end
            if (crank_rise) begin
                s_d.tcnt     = 20'h00000;
                s_d.tick_cnt = 20'h00000;
                s_d.sub      = 9'h000;
                case (pat)
                    CCPD_PAT_MISSING: begin
                        if (is_gap) begin
                            // Gap edge resyncs to the reference position
                            s_d.idx  = ref_pos;
                            s_d.sync = s_q.act_ctrl[CCPD_CTRL_SYNC_EN];
                        end else begin
                            s_d.idx  = idx_inc;
                            s_d.prev = period;
                        end
                    end
                    CCPD_PAT_EXTRA: begin
                        if (is_short) begin
                            // Retarded: the previous edge was the extra one; advanced: this one is
                            s_d.idx  = s_q.act_ctrl[CCPD_CTRL_RETARD] ? ref_pos : idx_inc - 10'h001;
                            s_d.sync = s_q.act_ctrl[CCPD_CTRL_SYNC_EN];
                            if (!s_q.act_ctrl[CCPD_CTRL_RETARD]) begin
                                s_d.idx = ref_pos;
                            end
                        end else begin
                            s_d.idx  = idx_inc;
                            s_d.prev = period;
                        end
                    end
                    default: begin
                        s_d.prev = period;
                        if (s_q.ref_seen || (phase_ref && !s_q.ref_d)) begin
                            s_d.idx      = 10'h000;
                            s_d.ref_seen = 1'b0;
                            s_d.sync     = s_q.act_ctrl[CCPD_CTRL_SYNC_EN];
                        end else begin
                            s_d.idx = idx_inc;
                        end
                    end
                endcase
            end
        end
        s_d.angle = 19'((19'(s_q.idx) << lvl) + 19'(s_q.sub));

        // Cam phase capture
        if (cam1_in && !s_q.cam1_d) begin
            s_d.cap1 = s_q.angle;
        end
        if (cam2_in && !s_q.cam2_d) begin
            s_d.cap2 = s_q.angle;
        end

        // Degree conversion: ticks*360 >> level, divided by tooth count
        prod   = 28'(s_q.angle) * 28'(CCPD_DEG_PER_REV);
        rem_sh = {s_q.div_rem[7:0], s_q.div_num[17]};
        if (!s_q.div_busy) begin
            if (s_q.angle != s_q.div_src) begin
                s_d.div_src  = s_q.angle;
                s_d.div_num  = 18'(prod >> lvl);
                s_d.div_rem  = 9'h000;
                s_d.div_q    = 18'h00000;
                s_d.div_cnt  = CCPD_DIV_STEPS;
                s_d.div_busy = (s_q.act_teeth != 8'h00);
            end
        end else begin
            s_d.div_num = {s_q.div_num[16:0], 1'b0};
            if (rem_sh >= {1'b0, s_q.act_teeth}) begin
                s_d.div_rem = rem_sh - {1'b0, s_q.act_teeth};
                s_d.div_q   = {s_q.div_q[16:0], 1'b1};
            end else begin
                s_d.div_rem = rem_sh;
                s_d.div_q   = {s_q.div_q[16:0], 1'b0};
            end
            s_d.div_cnt = s_q.div_cnt - 5'h01;
            if (s_q.div_cnt == 5'h01) begin
                s_d.div_busy = 1'b0;
                s_d.deg      = s_d.div_q[9:0];
            end
        end

        // Register reads, answered in the next cycle
        if (reg_rd) begin
            case (reg_addr)
                CCPD_REG_CTRL:     s_d.rdata = {24'h000000, s_q.ctrl};
                CCPD_REG_TEETH:    s_d.rdata = {24'h000000, s_q.teeth};
                CCPD_REG_DRV_MODE: s_d.rdata = 32'(s_q.drv_mode);
                CCPD_REG_CAM_COND: s_d.rdata = {16'h0000, s_q.cam_cond};
                CCPD_REG_STATUS:   s_d.rdata = {29'h00000000, active, cfg_err, s_q.sync};
                CCPD_REG_ANGLE:    s_d.rdata = {13'h0000, s_q.angle};
                CCPD_REG_DEGREES:  s_d.rdata = {22'h000000, s_q.deg};
                CCPD_REG_CAM1_CAP: s_d.rdata = {13'h0000, s_q.cap1};
                CCPD_REG_CAM2_CAP: s_d.rdata = {13'h0000, s_q.cap2};
                default: begin
                    if ((reg_addr >= CCPD_REG_TDC_BASE) && (int'(toff) < NCH)) begin
                        s_d.rdata = {16'h0000, s_q.tdc[toff]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q          <= '0;
            s_q.ctrl     <= CCPD_CTRL_RST;
            s_q.teeth    <= CCPD_TEETH_RST;
            s_q.act_ctrl <= CCPD_CTRL_RST;
            s_q.act_teeth <= CCPD_TEETH_RST;
            s_q.tdc      <= {NCH{CCPD_TDC_RST}};
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata           = s_q.rdata;
    assign in_sync             = s_q.sync;
    assign angle_ticks         = s_q.angle;
    assign angle_deg           = s_q.deg;
    assign manual_oneshot_fire = s_q.oneshot;
    assign tdc_values          = s_q.tdc;

endmodule // ccpd_decoder

// file: ccpd_decoder_assertions.sv
// Port-level checks for the crank and cam pattern decoder.
// Assumes it is bound to ccpd_decoder and sees only its ports.
`timescale 1ns/100ps
module ccpd_decoder_assertions
    import ccpd_pkg::*;
#(
    parameter int NUM_DI_CH  = 4,
    parameter int NUM_PFI_CH = 4,
    parameter int NUM_DRV    = 4
) (
    // Clock and reset
    input wire logic                                  clk,
    input wire logic                                  rstn,
    // Register port
    input wire logic [5:0]                            reg_addr,
    input wire logic [31:0]                           reg_wdata,
    input wire logic                                  reg_wr,
    input wire logic                                  reg_rd,
    input wire logic [31:0]                           reg_rdata,
    // Sensor and results
    input wire logic                                  crank_in,
    input wire logic                                  in_sync,
    input wire logic [18:0]                           angle_ticks,
    input wire logic [9:0]                            angle_deg,
    input wire logic [NUM_PFI_CH-1:0]                 manual_oneshot_fire,
    input wire logic [(NUM_DI_CH+NUM_PFI_CH)*16-1:0]  tdc_values
);
    logic [NUM_DRV-1:0] mode_q;
    logic [1:0]         pat_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // Mode and pattern as last written
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= '0;
            pat_q  <= CCPD_PAT_ENCODER;
        end else if (reg_wr && reg_addr == CCPD_REG_DRV_MODE) begin
            mode_q <= reg_wdata[NUM_DRV-1:0];
        end else if (reg_wr && reg_addr == CCPD_REG_CTRL) begin
            pat_q <= reg_wdata[1:0];
        end
    end

    oneshot_source_a: assert property (manual_oneshot_fire != '0 |-> $past(reg_wr) &&
        $past(reg_addr) == CCPD_REG_ONESHOT) else $error("stray one-shot pulse");
    oneshot_value_a: assert property (reg_wr && reg_addr == CCPD_REG_ONESHOT |=>
        manual_oneshot_fire == NUM_PFI_CH'($past(reg_wdata))) else $error("one-shot pulse bits wrong");
    idle_sync_a: assert property ((mode_q == '0)[*3] |-> !in_sync)
        else $error("sync while idle");
    idle_angle_a: assert property ((mode_q == '0)[*3] |-> angle_ticks == '0)
        else $error("angle moving while idle");
    tooth_align_a: assert property ($rose(crank_in) && in_sync && pat_q != CCPD_PAT_EXTRA
        |-> ##2 angle_ticks[6:0] == 7'h00) else $error("tooth off a whole position");
    degree_range_a: assert property (angle_deg < 10'h2d0)
        else $error("degrees out of range");
    tdc_write_a: assert property (reg_wr && reg_addr == CCPD_REG_TDC_BASE |=>
        tdc_values[15:0] == 16'($past(reg_wdata))) else $error("tdc 0 not taken");
    read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("stray read data");
    unmapped_read_a: assert property (reg_rd && reg_addr == 6'h3f |=> reg_rdata == '0)
        else $error("unmapped read not 0");
endmodule // ccpd_decoder_assertions

// file: ccpd_wheel_model.sv
// Crank wheel, reference tooth and two cam sensors for the decoder bench.
// Assumes PERIOD clocks per tooth position; outputs rest low while run is low.
`timescale 1ns/100ps
module ccpd_wheel_model #(
    parameter int PERIOD = 200
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    // Wheel shape
    input wire logic       run,
    input wire logic [7:0] teeth,
    input wire logic [1:0] missing,
    input wire logic [1:0] extra,
    // Sensor pins and position seen
    output logic           crank_in,
    output logic           cam1_in,
    output logic           cam2_in,
    output logic           ref_in,
    output logic [7:0]     pos,
    output logic           rev
);
    int   cnt;
    logic gap;
    logic xtra;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn || !run) begin
            cnt <= 0;
            pos <= 8'h00;
            rev <= 1'b0;
        end else if (cnt == PERIOD - 1) begin
            cnt <= 0;
            pos <= (pos == teeth - 8'h01) ? 8'h00 : pos + 8'h01;
            if (pos == teeth - 8'h01)
                rev <= ~rev;
        end else begin
            cnt <= cnt + 1;
        end
    end

    // Gap at the wheel end
    assign gap = pos >= teeth - {6'h00, missing};
    // Extra tooth, early or late
    assign xtra = pos == teeth - 8'h01 && (extra == 2'h1 ? cnt >= 12 && cnt < 16 :
                  extra == 2'h2 && cnt >= PERIOD - 28 && cnt < PERIOD - 24);
    assign crank_in = run && ((!gap && cnt < 8) || xtra);
    assign ref_in = run && pos == 8'h00 && cnt < 8;
    // Cam 1 high around every second wheel end; cam 2 high from mid position 4 through position 5 on every turn
    assign cam1_in = run && (rev ? pos > 8'h02 || (pos == 8'h02 && cnt >= PERIOD / 2) :
                     pos < 8'h02 || (pos == 8'h02 && cnt < PERIOD / 2));
    assign cam2_in = run && ((pos == 8'h04 && cnt >= PERIOD / 2) || pos == 8'h05);
endmodule // ccpd_wheel_model

// file: tb_top.sv
// Self-checking bench for the crank and cam pattern decoder.
// Assumes the wheel model drives the sensor pins.
`timescale 1ns/100ps
module tb_top;
    import ccpd_pkg::*;
    localparam int PER = 200;
    typedef struct {logic [5:0] a; logic [31:0] d; bit w; logic [31:0] e;} ccpd_row_t;
    logic         clk = 1'b0;
    logic         rstn = 1'b0;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic         run = 1'b0;
    logic [5:0]   reg_addr = 6'h00;
    logic [31:0]  reg_wdata = 32'h0;
    logic [1:0]   missing = 2'h0;
    logic [1:0]   extra = 2'h0;
    logic [31:0]  v;
    logic [31:0]  reg_rdata;
    logic         crank_in, cam1_in, cam2_in, ref_in, in_sync, rev;
    logic [7:0]   pos;
    logic [18:0]  angle_ticks;
    logic [9:0]   angle_deg;
    logic [3:0]   fire;
    logic [127:0] tdc;
    int           bad_count = 0;
    int           samples_checked = 0;
    logic [7:0]   cfg_c [5] = '{8'h89, 8'h91, 8'h8d, 8'h88, 8'h8c};
    logic [1:0]   cfg_m [5] = '{2'h1, 2'h2, 2'h1, 2'h0, 2'h0};
    ccpd_row_t    rows [12] = '{'{CCPD_REG_CTRL, 0, 0, 32'(CCPD_CTRL_RST)}, '{CCPD_REG_TEETH, 0, 0, 32'(CCPD_TEETH_RST)},
        '{6'h17, 0, 0, 32'(CCPD_TDC_RST)}, '{CCPD_REG_DRV_MODE, 0, 0, 0}, '{CCPD_REG_TDC_BASE, 'ha5a5, 1, 'ha5a5},
        '{6'h13, 'hbeef, 1, 'hbeef}, '{CCPD_REG_TEETH, 'h8, 1, 'h8}, '{6'h3f, 'hffff, 1, 0}, '{CCPD_REG_ONESHOT, 0, 1, 0},
        '{CCPD_REG_STATUS, 'h7, 1, 0}, '{CCPD_REG_CAM_COND, 'h302, 1, 'h302}, '{CCPD_REG_CAM_COND, 0, 1, 0}};

    always #12.5 clk = ~clk;

    ccpd_decoder dut_u (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .crank_in(crank_in), .cam1_in(cam1_in), .cam2_in(cam2_in),
        .ref_in(ref_in), .in_sync(in_sync), .angle_ticks(angle_ticks), .angle_deg(angle_deg),
        .manual_oneshot_fire(fire), .tdc_values(tdc));
    ccpd_wheel_model #(.PERIOD(PER)) wheel_u (.clk(clk), .rstn(rstn), .run(run), .teeth(8'h08), .missing(missing),
        .extra(extra), .crank_in(crank_in), .cam1_in(cam1_in), .cam2_in(cam2_in), .ref_in(ref_in), .pos(pos), .rev(rev));

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [5:0] a, logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [5:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Wheel restarts at position 0 for each setup
    task automatic setup(logic [7:0] ctrl, logic [1:0] m, logic [1:0] x, logic [3:0] mode);
        wr(CCPD_REG_DRV_MODE, 32'h0);
        run <= 1'b0;
        missing <= m;
        extra <= x;
        wr(CCPD_REG_CTRL, {24'h0, ctrl});
        wr(CCPD_REG_DRV_MODE, {28'h0, mode});
        run <= 1'b1;
        repeat (24 * PER) @(posedge clk);
    endtask
    task automatic pos_chk(bit c720);
        logic [11:0] exp;
        @(posedge clk iff (crank_in && pos == 8'h03));
        exp = {4'h0, pos} + ((c720 && rev) ? 12'h8 : 12'h0);
        repeat (2) @(posedge clk);
        #1 chk("tooth index", {20'h0, exp}, {20'h0, angle_ticks[18:7]});
        repeat (190) @(posedge clk);
        #1 chk("degrees", {20'h0, exp}, {22'h0, angle_deg / 10'd45});
    endtask
    task automatic done(string n);
        $display("Test %s finished", n);
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            chk("register", rows[i].e, v);
        end
        chk("tdc port", 32'hbeef, {16'h0, tdc[63:48]});
        done("registers");
        // Back-to-back one-shot writes
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= CCPD_REG_ONESHOT;
        reg_wdata <= 32'h5;
        @(posedge clk);
        reg_wdata <= 32'h1;
        #1 chk("one-shot", 32'h5, {28'h0, fire});
        @(posedge clk);
        reg_wr <= 1'b0;
        #1 chk("one-shot", 32'h1, {28'h0, fire});
        @(posedge clk);
        #1 chk("one-shot", 32'h0, {28'h0, fire});
        done("one-shot");
        setup(8'h89, 2'h1, 2'h0, 4'h0);
        chk("idle sync", 32'h0, {31'h0, in_sync});
        chk("idle angle", 32'h0, {13'h0, angle_ticks});
        for (int g = 0; g < 4; g += 3) begin
            setup(8'h81 | 8'(g << 3), 2'h1, 2'h0, 4'h1);
            rd(CCPD_REG_STATUS, v);
            chk("gap size error", 32'h1, {31'h0, v[1]});
            chk("error sync", 32'h0, {31'h0, in_sync});
        end
        done("idle and errors");
        foreach (cfg_c[i]) begin
            setup(cfg_c[i], cfg_m[i], 2'h0, 4'h1);
            chk("sync", 32'h1, {31'h0, in_sync});
            pos_chk(cfg_c[i][2]);
            if (i == 0) begin
                rd(CCPD_REG_CAM1_CAP, v);
                chk("cam1 capture", 32'h2, {20'h0, v[18:7]});
                rd(CCPD_REG_CAM2_CAP, v);
                chk("cam2 capture", 32'h4, {20'h0, v[18:7]});
            end
        end
        for (int x = 1; x < 3; x++) begin
            setup(x == 2 ? 8'ha2 : 8'h82, 2'h0, 2'(x), 4'h1);
            chk("extra tooth sync", 32'h1, {31'h0, in_sync});
        end
        done("patterns");
        wrap_up();
    end
endmodule // tb_top

bind ccpd_decoder ccpd_decoder_assertions #(.NUM_DI_CH(NUM_DI_CH), .NUM_PFI_CH(NUM_PFI_CH), .NUM_DRV(NUM_DRV)) chk_u (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .crank_in(crank_in), .in_sync(in_sync), .angle_ticks(angle_ticks),
    .angle_deg(angle_deg), .manual_oneshot_fire(manual_oneshot_fire), .tdc_values(tdc_values));
